// *** hw/esse_exec.sv ***
// Execution unit for skip, subtract and nibble-exchange instructions
`timescale 1ns/1ps

// Function
// - Increment-skip-to-accumulator puts the addressed byte plus one into the accumulator and leaves memory alone.
// - Increment-skip-to-accumulator skips the next instruction when that sum is zero.
// - A taken skip inserts a dummy cycle before the refetch cycle, so the instruction lasts three cycles.
// - Skip-bit-nonzero skips when the selected bit of the byte is one.
// - Skip-byte-nonzero writes the byte back unchanged and skips when it is not zero.
// - An unmet skip condition lets the following instruction run with no skip.
// - Subtract-into-accumulator stores accumulator minus byte in the accumulator.
// - Subtract-into-memory stores accumulator minus byte in memory and keeps the accumulator.
// - Both subtracts clear carry on a negative difference and set it on zero or positive.
// - Both subtracts update overflow, zero, auxiliary carry, carry, signed carry and chained zero.
// - Nibble exchange in place swaps the byte halves and writes the result back to memory.
// - Nibble exchange to accumulator puts the swapped byte in the accumulator and leaves memory alone.
// - Skip-byte-zero writes the byte back unchanged and skips when it is zero.
// - Load-skip-zero copies the byte to the accumulator and skips when it is zero.
// - Skip-bit-zero skips when the selected bit of the byte is cleared.
module esse_exec (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Instruction issue
  input  wire logic                  issueValid,
  input  wire esse_pkg::esse_issue_s issue,
  output logic                       issueReady,
  // Write-back and pipeline control
  output esse_pkg::esse_result_s     result,
  output logic                       dummyCycle
);

  typedef enum logic [1:0] {
    ST_RUN,
    ST_DUMMY,
    ST_REFETCH
  } esse_state_e;

  esse_state_e            state;
  esse_state_e            next_state;
  esse_pkg::esse_result_s next_result;
  logic                   taken;
  logic [7:0]             incSum;
  logic [7:0]             swapped;
  logic [7:0]             diff;
  logic                   selBit;
  esse_pkg::esse_flags_s  subFlags;

  // Handshake: new instruction only while not inside a skip
  assign issueReady = (state == ST_RUN);
  assign dummyCycle = (state == ST_DUMMY);
  assign taken      = issueValid && issueReady;

  // Operand shaping shared by several instructions
  assign incSum  = issue.memData + esse_pkg::ONE_BYTE;
  assign swapped = {issue.memData[esse_pkg::NIB_LO_MSB:esse_pkg::NIB_LO_LSB],
                    issue.memData[esse_pkg::NIB_HI_MSB:esse_pkg::NIB_HI_LSB]};
  assign diff    = issue.acc - issue.memData;
  assign selBit  = issue.memData[issue.bitSel];

  // Subtract flags
  always_comb begin
    subFlags                   = '0;
    subFlags.carry             = (issue.acc >= issue.memData);
    subFlags.auxCarry          = (issue.acc[esse_pkg::NIB_LO_MSB:esse_pkg::NIB_LO_LSB] >=
                                  issue.memData[esse_pkg::NIB_LO_MSB:esse_pkg::NIB_LO_LSB]);
    subFlags.zero              = (diff == esse_pkg::ZERO_BYTE);
    subFlags.overflow          = (issue.acc[esse_pkg::SIGN_BIT] != issue.memData[esse_pkg::SIGN_BIT]) &&
                                 (diff[esse_pkg::SIGN_BIT] != issue.acc[esse_pkg::SIGN_BIT]);
    subFlags.signed_carry_flag = diff[esse_pkg::SIGN_BIT] ^ subFlags.overflow;
    subFlags.chained_zero_flag = subFlags.zero;
  end

  // Decode and write-back selection
  always_comb begin
    next_result       = esse_pkg::RESULT_IDLE;
    next_result.flags = issue.flags;
    if (taken) begin
      next_result.valid = 1'b1;
      case (issue.op)
        esse_pkg::OP_INC_SKIP_ZERO_TO_A_REG: begin
          next_result.accWe   = 1'b1;
          next_result.accData = incSum;
          next_result.skip    = (incSum == esse_pkg::ZERO_BYTE);
        end
        esse_pkg::OP_SKIP_BIT_NONZERO: begin
          next_result.skip = selBit;
        end
        esse_pkg::OP_SKIP_BYTE_NONZERO: begin
          next_result.memWe   = 1'b1;
          next_result.memData = issue.memData;
          next_result.skip    = (issue.memData != esse_pkg::ZERO_BYTE);
        end
        esse_pkg::OP_SUBTRACT_INTO_A_REG: begin
          next_result.accWe   = 1'b1;
          next_result.accData = diff;
          next_result.flagsWe = 1'b1;
          next_result.flags   = subFlags;
        end
        esse_pkg::OP_SUBTRACT_INTO_MEMORY: begin
          next_result.memWe   = 1'b1;
          next_result.memData = diff;
          next_result.flagsWe = 1'b1;
          next_result.flags   = subFlags;
        end
        esse_pkg::OP_NIBBLE_EXCHANGE_IN_PLACE: begin
          next_result.memWe   = 1'b1;
          next_result.memData = swapped;
        end
        esse_pkg::OP_NIBBLE_EXCHANGE_TO_A_REG: begin
          next_result.accWe   = 1'b1;
          next_result.accData = swapped;
        end
        esse_pkg::OP_SKIP_BYTE_ZERO: begin
          next_result.memWe   = 1'b1;
          next_result.memData = issue.memData;
          next_result.skip    = (issue.memData == esse_pkg::ZERO_BYTE);
        end
        esse_pkg::OP_LOAD_SKIP_ZERO: begin
          next_result.accWe   = 1'b1;
          next_result.accData = issue.memData;
          next_result.skip    = (issue.memData == esse_pkg::ZERO_BYTE);
        end
        esse_pkg::OP_SKIP_BIT_ZERO: begin
          next_result.skip = !selBit;
        end
        default: begin
          next_result.valid = 1'b0;
        end
      endcase
    end
  end

  // Skip sequencing: dummy cycle, then refetch, then run
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (next_result.skip) begin
          next_state = ST_DUMMY;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_DUMMY: begin
        next_state = ST_REFETCH;
      end
      ST_REFETCH: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // State and write-back registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state  <= ST_RUN;
      result <= esse_pkg::RESULT_IDLE;
    end else begin
      state  <= next_state;
      result <= next_result;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  inc_to_acc_a: assert property (taken && issue.op == esse_pkg::OP_INC_SKIP_ZERO_TO_A_REG |=>
      result.accWe && !result.memWe && result.accData == $past(issue.memData) + 8'h01)
    else $error("increment to accumulator wrong");
  inc_skip_a: assert property (taken && issue.op == esse_pkg::OP_INC_SKIP_ZERO_TO_A_REG |=>
      result.skip == ($past(issue.memData) == 8'hFF))
    else $error("increment skip decision wrong");
  skip_length_a: assert property (result.valid && result.skip |->
      dummyCycle && !issueReady ##1 !dummyCycle && !issueReady ##1 issueReady)
    else $error("taken skip does not last three cycles");
  bit_nonzero_a: assert property (taken && issue.op == esse_pkg::OP_SKIP_BIT_NONZERO |=>
      result.skip == $past(selBit) && !result.memWe && !result.accWe)
    else $error("bit nonzero skip wrong");
  byte_nonzero_a: assert property (taken && issue.op == esse_pkg::OP_SKIP_BYTE_NONZERO |=>
      result.memWe && result.memData == $past(issue.memData) && result.skip == (result.memData != 8'h00))
    else $error("byte nonzero skip wrong");
  no_skip_a: assert property (result.valid && !result.skip |-> issueReady && !dummyCycle)
    else $error("untaken skip stalled");
  sub_acc_a: assert property (taken && issue.op == esse_pkg::OP_SUBTRACT_INTO_A_REG |=>
      result.accWe && !result.memWe && result.accData == 8'($past(issue.acc) - $past(issue.memData)))
    else $error("subtract to accumulator wrong");
  sub_mem_a: assert property (taken && issue.op == esse_pkg::OP_SUBTRACT_INTO_MEMORY |=>
      result.memWe && !result.accWe && result.memData == 8'($past(issue.acc) - $past(issue.memData)))
    else $error("subtract to memory wrong");
  sub_carry_a: assert property (taken && (issue.op == esse_pkg::OP_SUBTRACT_INTO_A_REG ||
      issue.op == esse_pkg::OP_SUBTRACT_INTO_MEMORY) |=>
      result.flagsWe && result.flags.carry == ($past(issue.acc) >= $past(issue.memData)))
    else $error("subtract carry wrong");
  sub_zero_a: assert property (result.valid && result.flagsWe |->
      result.flags.zero == (result.accWe ? result.accData == 8'h00 : result.memData == 8'h00) &&
      result.flags.chained_zero_flag == result.flags.zero)
    else $error("subtract zero flags wrong");
  swap_mem_a: assert property (taken && issue.op == esse_pkg::OP_NIBBLE_EXCHANGE_IN_PLACE |=>
      result.memWe && result.memData == {$past(issue.memData[3:0]), $past(issue.memData[7:4])})
    else $error("nibble exchange in place wrong");
  swap_acc_a: assert property (taken && issue.op == esse_pkg::OP_NIBBLE_EXCHANGE_TO_A_REG |=>
      result.accWe && !result.memWe && result.accData == {$past(issue.memData[3:0]), $past(issue.memData[7:4])})
    else $error("nibble exchange to accumulator wrong");
  byte_zero_a: assert property (taken && issue.op == esse_pkg::OP_SKIP_BYTE_ZERO |=>
      result.memWe && result.memData == $past(issue.memData) && result.skip == (result.memData == 8'h00))
    else $error("byte zero skip wrong");
  load_skip_a: assert property (taken && issue.op == esse_pkg::OP_LOAD_SKIP_ZERO |=>
      result.accWe && result.accData == $past(issue.memData) && result.skip == (result.accData == 8'h00))
    else $error("load skip zero wrong");
  bit_zero_a: assert property (taken && issue.op == esse_pkg::OP_SKIP_BIT_ZERO |=>
      result.skip == !$past(selBit))
    else $error("bit zero skip wrong");
  flags_kept_a: assert property (result.valid && !result.flagsWe |-> result.flags == $past(issue.flags))
    else $error("flags changed by non-arithmetic instruction");

  skip_taken_c:  cover property (result.valid && result.skip ##2 issueReady);
  sub_borrow_c:  cover property (result.valid && result.flagsWe && !result.flags.carry);
  sub_ovf_c:     cover property (result.valid && result.flags.overflow);
  back_to_back_c: cover property (result.valid && !result.skip ##1 result.valid);

endmodule

// *** hw/esse_pkg.sv ***
// Package with opcodes, flag and result carriers and constants of the execution unit
package esse_pkg;

  // Data path widths and fixed values
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned BITSEL_W = 3;
  localparam logic [7:0]  ZERO_BYTE = 8'h00;
  localparam logic [7:0]  ONE_BYTE  = 8'h01;

  // Nibble field positions
  localparam int unsigned NIB_LO_MSB = 3;
  localparam int unsigned NIB_LO_LSB = 0;
  localparam int unsigned NIB_HI_MSB = 7;
  localparam int unsigned NIB_HI_LSB = 4;
  localparam int unsigned SIGN_BIT   = 7;

  // Cycles a taken skip occupies, counted from the issue cycle
  localparam int unsigned SKIP_CYCLES = 3;

  // Instructions handled here
  typedef enum logic [3:0] {
    OP_INC_SKIP_ZERO_TO_A_REG,
    OP_SKIP_BIT_NONZERO,
    OP_SKIP_BYTE_NONZERO,
    OP_SUBTRACT_INTO_A_REG,
    OP_SUBTRACT_INTO_MEMORY,
    OP_NIBBLE_EXCHANGE_IN_PLACE,
    OP_NIBBLE_EXCHANGE_TO_A_REG,
    OP_SKIP_BYTE_ZERO,
    OP_LOAD_SKIP_ZERO,
    OP_SKIP_BIT_ZERO
  } esse_op_e;

  // Arithmetic status flags
  typedef struct packed {
    logic overflow;
    logic zero;
    logic auxCarry;
    logic carry;
    logic signed_carry_flag;
    logic chained_zero_flag;
  } esse_flags_s;

  // Issued instruction with its operands
  typedef struct packed {
    esse_op_e                op;
    logic [DATA_W-1:0]       memData;
    logic [DATA_W-1:0]       acc;
    logic [BITSEL_W-1:0]     bitSel;
    esse_flags_s             flags;
  } esse_issue_s;

  // Registered write-back of one instruction
  typedef struct packed {
    logic                    valid;
    logic                    accWe;
    logic [DATA_W-1:0]       accData;
    logic                    memWe;
    logic [DATA_W-1:0]       memData;
    logic                    flagsWe;
    esse_flags_s             flags;
    logic                    skip;
  } esse_result_s;

  // Reset value of the write-back
  localparam esse_result_s RESULT_IDLE = '0;

endpackage

// *** testbench/tb_extended_skip_subtract_swap_exec.sv ***
// Self-checking bench for the skip, subtract and nibble-exchange execution unit
`timescale 1ns/1ps

module tb_extended_skip_subtract_swap_exec;
  // Table row: inputs, expected {accWe,memWe,flagsWe,skip}, accData, memData, flags
  typedef struct packed {
    esse_pkg::esse_op_e op;
    logic [7:0]         m;
    logic [7:0]         a;
    logic [2:0]         b;
    logic [3:0]         we;
    logic [7:0]         ad;
    logic [7:0]         md;
    logic [5:0]         fl;
  } esse_row_s;

  // Design ports and bench counters
  logic                   clk;
  logic                   reset;
  logic                   issueValid;
  esse_pkg::esse_issue_s  issue;
  logic                   issueReady;
  esse_pkg::esse_result_s result;
  logic                   dummyCycle;
  int                     error_cnt;
  int                     compares;

  // Ordinary cases, incoming flags always 2A
  esse_row_s rows [18] = '{
    '{esse_pkg::OP_INC_SKIP_ZERO_TO_A_REG, 8'hFF, 8'h33, 3'h0, 4'h9, 8'h00, 8'h00, 6'h2A},
    '{esse_pkg::OP_INC_SKIP_ZERO_TO_A_REG, 8'h41, 8'h33, 3'h0, 4'h8, 8'h42, 8'h00, 6'h2A},
    '{esse_pkg::OP_SKIP_BIT_NONZERO, 8'h08, 8'h33, 3'h3, 4'h1, 8'h00, 8'h00, 6'h2A},
    '{esse_pkg::OP_SKIP_BIT_NONZERO, 8'h7F, 8'h33, 3'h7, 4'h0, 8'h00, 8'h00, 6'h2A},
    '{esse_pkg::OP_SKIP_BYTE_NONZERO, 8'h01, 8'h33, 3'h0, 4'h5, 8'h00, 8'h01, 6'h2A},
    '{esse_pkg::OP_SKIP_BYTE_NONZERO, 8'h00, 8'h33, 3'h0, 4'h4, 8'h00, 8'h00, 6'h2A},
    '{esse_pkg::OP_SUBTRACT_INTO_A_REG, 8'h07, 8'h05, 3'h0, 4'hA, 8'hFE, 8'h00, 6'h02},
    '{esse_pkg::OP_SUBTRACT_INTO_A_REG, 8'h01, 8'h80, 3'h0, 4'hA, 8'h7F, 8'h00, 6'h26},
    '{esse_pkg::OP_SUBTRACT_INTO_MEMORY, 8'h37, 8'h37, 3'h0, 4'h6, 8'h00, 8'h00, 6'h1D},
    '{esse_pkg::OP_SUBTRACT_INTO_MEMORY, 8'hFF, 8'h7F, 3'h0, 4'h6, 8'h00, 8'h80, 6'h28},
    '{esse_pkg::OP_NIBBLE_EXCHANGE_IN_PLACE, 8'hA5, 8'h33, 3'h0, 4'h4, 8'h00, 8'h5A, 6'h2A},
    '{esse_pkg::OP_NIBBLE_EXCHANGE_TO_A_REG, 8'h3C, 8'h33, 3'h0, 4'h8, 8'hC3, 8'h00, 6'h2A},
    '{esse_pkg::OP_SKIP_BYTE_ZERO, 8'h00, 8'h33, 3'h0, 4'h5, 8'h00, 8'h00, 6'h2A},
    '{esse_pkg::OP_SKIP_BYTE_ZERO, 8'h10, 8'h33, 3'h0, 4'h4, 8'h00, 8'h10, 6'h2A},
    '{esse_pkg::OP_LOAD_SKIP_ZERO, 8'h00, 8'h33, 3'h0, 4'h9, 8'h00, 8'h00, 6'h2A},
    '{esse_pkg::OP_LOAD_SKIP_ZERO, 8'h9E, 8'h33, 3'h0, 4'h8, 8'h9E, 8'h00, 6'h2A},
    '{esse_pkg::OP_SKIP_BIT_ZERO, 8'hFE, 8'h33, 3'h0, 4'h1, 8'h00, 8'h00, 6'h2A},
    '{esse_pkg::OP_SKIP_BIT_ZERO, 8'h01, 8'h33, 3'h0, 4'h0, 8'h00, 8'h00, 6'h2A}
  };

  // Unit under test
  esse_exec dut (
    .clk        (clk),
    .reset      (reset),
    .issueValid (issueValid),
    .issue      (issue),
    .issueReady (issueReady),
    .result     (result),
    .dummyCycle (dummyCycle)
  );

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // One comparison, counted
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Counts and verdict, then stop
  task automatic final_report;
    $display("Compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Issue one row; valid stays high through a skip so refused issues are seen
  task automatic do_row(input esse_row_s r);
    issueValid     = 1'h1;
    issue.op       = r.op;
    issue.memData  = r.m;
    issue.acc      = r.a;
    issue.bitSel   = r.b;
    issue.flags    = 6'h2A;
    @(negedge clk);
    chk({3'h0, result.valid, result.accWe, result.memWe, result.flagsWe, result.skip}, {4'h1, r.we});
    if (r.we[3]) chk(result.accData, r.ad);
    if (r.we[2]) chk(result.memData, r.md);
    chk({2'h0, result.flags}, {2'h0, r.fl});
    chk({6'h0, dummyCycle, issueReady}, {6'h0, r.we[0], ~r.we[0]});
    if (r.we[0]) begin
      @(negedge clk);
      chk({5'h0, result.valid, dummyCycle, issueReady}, 8'h00);
      @(negedge clk);
      chk({5'h0, result.valid, dummyCycle, issueReady}, 8'h01);
    end
  endtask

  // Main sequence
  initial begin
    clk        = 1'h0;
    reset      = 1'h1;
    issueValid = 1'h0;
    issue      = '0;
    error_cnt  = 0;
    compares   = 0;
    repeat (8) @(negedge clk);
    reset = 1'h0;
    @(negedge clk);
    chk({5'h0, result.valid, dummyCycle, issueReady}, 8'h01);
    $display("Test reset done");
    foreach (rows[i]) do_row(rows[i]);
    $display("Test table done");
    // Unknown opcode gives no result
    issue.op = esse_pkg::esse_op_e'(4'hF);
    @(negedge clk);
    issueValid = 1'h0;
    chk({7'h0, result.valid}, 8'h00);
    $display("Test unknown opcode done");
    // Reset in the squashed slot of a taken skip
    @(negedge clk);
    issue.op      = esse_pkg::OP_SKIP_BYTE_ZERO;
    issue.memData = 8'h00;
    issueValid    = 1'h1;
    @(negedge clk);
    chk({6'h0, dummyCycle, issueReady}, 8'h02);
    reset      = 1'h1;
    issueValid = 1'h0;
    @(negedge clk);
    chk({5'h0, result.valid, dummyCycle, issueReady}, 8'h01);
    reset = 1'h0;
    @(negedge clk);
    chk({5'h0, result.valid, dummyCycle, issueReady}, 8'h01);
    $display("Test mid-run reset done");
    final_report();
  end

  // Watchdog far beyond the expected run of under 100 cycles
  initial begin
    #(2000 * 5);
    error_cnt++;
    $display("Error at %0t: got %h expected %h", $time, 8'h00, 8'h01);
    final_report();
  end
endmodule
